// ===== include/pump_link_params.svh
`ifndef PUMP_LINK_PARAMS_SVH
`define PUMP_LINK_PARAMS_SVH

// Command bands in percent of one measured period
`define CMD_RUN_MIN_PCT 15
`define CMD_RUN_MAX_PCT 47
`define CMD_LOW_SPEED_PCT 37
`define CMD_HIGH_SPEED_PCT 47
`define CMD_INV_ON_A_MIN_PCT 51
`define CMD_OFF_MIN_PCT 67
`define CMD_OFF_MAX_PCT 83
// Feedback duty values in percent
`define FB_INVALID_PCT 20
`define FB_EVENT_PCT 40
`define FB_NORMAL_PCT 60
`define FB_SECONDARY_PCT 80
// Timing
`define CLK_PERIOD_NS 8
`define PWM_PERIOD_US 1000
`define PWM_PERIOD_CYC ((`PWM_PERIOD_US * 1000) / `CLK_PERIOD_NS)
`define LOSS_PERIODS 4
`define DUTY_STEPS 200

`endif

// ===== include/pump_link_pkg.sv
package pump_link_pkg;
    typedef enum logic [2:0] {
        CMD_NONE,
        CMD_INVALID,
        CMD_RUN,
        CMD_OFF
    } cmd_class_t;
    typedef enum logic [1:0] {
        FB_INVALID,
        FB_EVENT,
        FB_NORMAL,
        FB_SECONDARY
    } fb_code_t;
endpackage : pump_link_pkg

// ===== hw/pwm_out.sv
`timescale 1ns/1ns
`default_nettype none
module pwm_out #(
    parameter int PERIOD_CYC = 125000,
    parameter int CW = 17
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [CW-1:0] high_cyc_in,
    output logic pwm_out
);
    logic [CW-1:0] cnt_r;
    logic [CW-1:0] high_r;
    wire wrap = (cnt_r == CW'(PERIOD_CYC - 1));

    initial begin
        if (PERIOD_CYC < 2 || PERIOD_CYC >= (1 << CW)) $error("pwm_out period");
    end

    // High time latched at period start, so a mid-period change never glitches
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            cnt_r <= '0;
            high_r <= '0;
            pwm_out <= 1'b0;
        end else begin
            cnt_r <= wrap ? '0 : cnt_r + 1'b1;
            if (wrap) high_r <= high_cyc_in;
            pwm_out <= (wrap ? high_cyc_in : high_r) > (wrap ? '0 : cnt_r + 1'b1);
        end
    end
endmodule : pwm_out
`default_nettype wire

// ===== hw/pump_module_link.sv
`timescale 1ns/1ns
`default_nettype none
`include "pump_link_params.svh"
////////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Command duty in 15-47% requests the pump to run at commanded speed.
// - Pump drive duty is twice the received command duty, of battery.
// - Command 0-15% is invalid off; pump off, feedback 20%.
// - Command 37% runs low speed; feedback 60%.
// - Command 47% runs high speed; feedback 60%.
// - Command 51-67% or 83-100% is invalid; pump off, feedback 20%.
// - Command 67-83% is valid off; pump off, feedback 60%.
// - Feedback 40% means bad crash input if fitted, else normal.
// - With crash notification fitted, normal operation reports 60%.
// - Secondary circuit fault reports 80% feedback.
module pump_module_link
    import pump_link_pkg::*;
#(
    parameter int PERIOD_CYC = `PWM_PERIOD_CYC,
    parameter int LOSS_PERIODS = `LOSS_PERIODS,
    parameter int CW = 20
) (
    input wire logic SYS_CLK_IN,
    input wire logic RST_IN,
    input wire logic PUMP_SPEED_COMMAND_IN,
    input wire logic CRASH_NOTIFY_FITTED_IN,
    input wire logic CRASH_INPUT_INVALID_IN,
    input wire logic SECONDARY_FAULT_IN,
    output logic PUMP_DRIVE_OUT,
    output logic PUMP_ON_OUT,
    output logic PUMP_HEALTH_FEEDBACK_OUT,
    output logic CMD_ABSENT_OUT
);
    localparam int DW = 8;
    localparam int PW = CW - 2;

    initial begin
        if (PERIOD_CYC < 200 || PERIOD_CYC * (LOSS_PERIODS + 1) >= (1 << CW) || LOSS_PERIODS < 2)
            $error("pump_module_link parameters");
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchroniser, three stages
    logic [2:0] sync_r;
    logic cmd_lvl_r;
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            sync_r <= 3'h0;
            cmd_lvl_r <= 1'b0;
        end else begin
            sync_r <= {sync_r[1:0], PUMP_SPEED_COMMAND_IN};
            if (sync_r[2] == sync_r[1]) cmd_lvl_r <= sync_r[2];
        end
    end
    wire rise = sync_r[2] & sync_r[1] & ~cmd_lvl_r;
    wire fall = ~sync_r[2] & ~sync_r[1] & cmd_lvl_r;

    ////////////////////////////////////////////////////////////////////////////
    // Duty measurement over complete periods, rising edge to rising edge
    logic [CW-1:0] per_cnt_r;
    logic [CW-1:0] high_cnt_r;
    logic [CW-1:0] idle_cnt_r;
    logic seen_rise_r;
    logic [DW-1:0] duty_r;
    logic meas_valid_r;
    logic absent_r;

    function automatic logic [DW-1:0] to_pct(input logic [CW-1:0] hi, input logic [CW-1:0] per);
        logic [CW+7:0] scaled;
        scaled = {8'h0, hi} * (CW+8)'(100);
        return (per == '0) ? '0 : DW'(scaled / {8'h0, per});
    endfunction : to_pct

    wire idle_lim = (idle_cnt_r >= CW'(PERIOD_CYC * LOSS_PERIODS));
    wire [DW-1:0] period_pct = to_pct(high_cnt_r, per_cnt_r);

    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            per_cnt_r <= '0;
            high_cnt_r <= '0;
            idle_cnt_r <= '0;
            seen_rise_r <= 1'b0;
            duty_r <= '0;
            meas_valid_r <= 1'b0;
            absent_r <= 1'b1;
        end else begin
            idle_cnt_r <= (rise | fall) ? '0 : (idle_lim ? idle_cnt_r : idle_cnt_r + 1'b1);
            if (idle_lim) begin
                absent_r <= 1'b1;
                meas_valid_r <= 1'b0;
                seen_rise_r <= 1'b0;
                // Steady level is a full 0% or 100% command
                duty_r <= cmd_lvl_r ? DW'(100) : DW'(0);
            end else if (rise) begin
                seen_rise_r <= 1'b1;
                per_cnt_r <= CW'(1);
                high_cnt_r <= CW'(1);
                if (seen_rise_r) begin
                    duty_r <= period_pct;
                    meas_valid_r <= 1'b1;
                    absent_r <= 1'b0;
                end
            end else begin
                per_cnt_r <= per_cnt_r + 1'b1;
                if (cmd_lvl_r) high_cnt_r <= high_cnt_r + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command classification
    wire steady = absent_r;
    wire [DW-1:0] pct = duty_r;
    wire in_low_band = (pct < DW'(`CMD_RUN_MIN_PCT));
    wire in_run_band = (pct >= DW'(`CMD_RUN_MIN_PCT)) && (pct <= DW'(`CMD_RUN_MAX_PCT));
    wire in_off_band = (pct >= DW'(`CMD_OFF_MIN_PCT)) && (pct <= DW'(`CMD_OFF_MAX_PCT));
    // 48-50% undocumented; treated as invalid on, like 51-67% above it
    wire in_bad_band = !in_low_band && !in_run_band && !in_off_band;
    wire have_cmd = meas_valid_r | steady;
    cmd_class_t cls;
    assign cls = !have_cmd ? CMD_NONE :
                 in_run_band ? CMD_RUN :
                 in_off_band ? CMD_OFF : CMD_INVALID;
    wire run_req = (cls == CMD_RUN);

    ////////////////////////////////////////////////////////////////////////////
    // Pump drive at twice the command duty
    localparam int DRV_CW = CW;
    wire [DW-1:0] drive_pct = run_req ? DW'({pct, 1'b0}) : '0;
    wire [CW+7:0] drive_prod = {8'h0, CW'(PERIOD_CYC)} * (CW+8)'(drive_pct);
    wire [DRV_CW-1:0] drive_high = DRV_CW'(drive_prod / (CW+8)'(100));
    logic pump_pwm;
    pwm_out #(.PERIOD_CYC(PERIOD_CYC), .CW(DRV_CW)) u_drive (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .high_cyc_in(drive_high),
        .pwm_out(pump_pwm)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Feedback code selection; secondary fault outranks all
    fb_code_t fb;
    assign fb = SECONDARY_FAULT_IN ? FB_SECONDARY :
                (cls == CMD_INVALID) ? FB_INVALID :
                (CRASH_NOTIFY_FITTED_IN && CRASH_INPUT_INVALID_IN) ? FB_EVENT :
                CRASH_NOTIFY_FITTED_IN ? FB_NORMAL :
                FB_EVENT;
    function automatic logic [DW-1:0] fb_pct(input fb_code_t c);
        unique case (c)
            FB_INVALID: return DW'(`FB_INVALID_PCT);
            FB_EVENT: return DW'(`FB_EVENT_PCT);
            FB_NORMAL: return DW'(`FB_NORMAL_PCT);
            FB_SECONDARY: return DW'(`FB_SECONDARY_PCT);
        endcase
    endfunction : fb_pct
    wire [CW+7:0] fb_prod = {8'h0, CW'(PERIOD_CYC)} * (CW+8)'(fb_pct(fb));
    wire [CW-1:0] fb_high = CW'(fb_prod / (CW+8)'(100));
    logic fb_pwm;
    pwm_out #(.PERIOD_CYC(PERIOD_CYC), .CW(CW)) u_fb (
        .clk_in(SYS_CLK_IN),
        .rst_in(RST_IN),
        .high_cyc_in(fb_high),
        .pwm_out(fb_pwm)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registered outputs
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            PUMP_DRIVE_OUT <= 1'b0;
            PUMP_ON_OUT <= 1'b0;
            PUMP_HEALTH_FEEDBACK_OUT <= 1'b0;
            CMD_ABSENT_OUT <= 1'b1;
        end else begin
            PUMP_DRIVE_OUT <= pump_pwm & run_req;
            PUMP_ON_OUT <= run_req;
            PUMP_HEALTH_FEEDBACK_OUT <= fb_pwm;
            CMD_ABSENT_OUT <= absent_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    chk_off_no_drive: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        !run_req |=> !PUMP_DRIVE_OUT) else $error("pump driven while not running");
    chk_run_band_on: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (have_cmd && pct >= 8'h0f && pct <= 8'h2f) |=> PUMP_ON_OUT) else $error("run band not on");
    chk_offband_off: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (have_cmd && pct >= 8'h43 && pct <= 8'h53) |=> !PUMP_ON_OUT) else $error("off band ran pump");
    chk_low_invalid: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (have_cmd && pct < 8'h0f && !SECONDARY_FAULT_IN) |-> fb == FB_INVALID) else $error("low band not invalid");
    chk_bad_invalid: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (have_cmd && (pct > 8'h53 || (pct > 8'h2f && pct < 8'h43)) && !SECONDARY_FAULT_IN)
        |-> fb == FB_INVALID) else $error("bad band not invalid");
    chk_secondary_fb: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        SECONDARY_FAULT_IN |-> fb_high == CW'((PERIOD_CYC * 80) / 100)) else $error("secondary not 80");
    chk_normal_fb: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (CRASH_NOTIFY_FITTED_IN && !CRASH_INPUT_INVALID_IN && !SECONDARY_FAULT_IN && run_req)
        |-> fb_high == CW'((PERIOD_CYC * 60) / 100)) else $error("normal not 60");
    chk_event_fb: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        (!SECONDARY_FAULT_IN && cls != CMD_INVALID && (!CRASH_NOTIFY_FITTED_IN || CRASH_INPUT_INVALID_IN))
        |-> fb_high == CW'((PERIOD_CYC * 40) / 100)) else $error("event not 40");
    chk_double_duty: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        run_req |-> drive_pct == DW'({pct, 1'b0})) else $error("drive not doubled");
    chk_absent_flag: assert property (@(posedge SYS_CLK_IN) disable iff (RST_IN)
        idle_lim |=> ##1 CMD_ABSENT_OUT) else $error("absent not flagged");
endmodule : pump_module_link
`default_nettype wire

// ===== test/engine_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module engine_ctrl_model
    import pump_link_pkg::*;
#(
    parameter int P = 200
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic run_in,
    input var int duty_in,
    input wire logic fb_in,
    output logic cmd_out,
    output int fb_pct_out,
    output fb_code_t fb_code_out,
    output logic fb_lost_out
);
    int ph = 0;
    int hi = 0;
    int quiet = 0;
    initial cmd_out = 1'b0;
    initial fb_pct_out = 0;
    // Whole periods only, a flat line counts as silence
    always @(posedge clk_in) begin
        if (rst_in) begin
            ph = 0;
            hi = 0;
            quiet = 0;
            fb_lost_out <= 1'b0;
        end else begin
            hi = hi + ((fb_in === 1'b1) ? 1 : 0);
            ph = ph + 1;
            if (ph == P) begin
                fb_pct_out <= hi * 100 / P;
                quiet = (hi == 0 || hi == P) ? quiet + 1 : 0;
                fb_lost_out <= (quiet >= 2);
                ph = 0;
                hi = 0;
            end
        end
        cmd_out <= #1 !rst_in && run_in && (ph < duty_in * P / 100);
    end
    // One fault class per feedback value
    always_comb begin
        if (fb_pct_out < 30) fb_code_out = FB_INVALID;
        else if (fb_pct_out < 50) fb_code_out = FB_EVENT;
        else if (fb_pct_out < 70) fb_code_out = FB_NORMAL;
        else fb_code_out = FB_SECONDARY;
    end
endmodule : engine_ctrl_model
`default_nettype wire

// ===== test/tb_fuel_pump_duty_cycle_link.sv
`timescale 1ns/1ns
`default_nettype none
module tb_fuel_pump_duty_cycle_link;
    import pump_link_pkg::*;
    localparam int P = 200;
    logic clk = 1'b0, rst = 1'b1, mrst = 1'b1, fitted = 1'b1, crash_bad = 1'b0, sec_fault = 1'b0, run = 1'b1;
    logic cmd, drive, pump_on, fb, absent, fb_lost;
    int duty = 75, fb_pct, n_fail = 0, n_tests = 0, cycles = 0;
    fb_code_t fb_code;
    always #4 clk = ~clk;
    pump_module_link #(.PERIOD_CYC(P), .LOSS_PERIODS(4)) DUT (.SYS_CLK_IN(clk), .RST_IN(rst),
        .PUMP_SPEED_COMMAND_IN(cmd), .CRASH_NOTIFY_FITTED_IN(fitted), .CRASH_INPUT_INVALID_IN(crash_bad),
        .SECONDARY_FAULT_IN(sec_fault), .PUMP_DRIVE_OUT(drive), .PUMP_ON_OUT(pump_on),
        .PUMP_HEALTH_FEEDBACK_OUT(fb), .CMD_ABSENT_OUT(absent));
    engine_ctrl_model #(.P(P)) partner (.clk_in(clk), .rst_in(mrst), .run_in(run), .duty_in(duty),
        .fb_in(fb), .cmd_out(cmd), .fb_pct_out(fb_pct), .fb_code_out(fb_code), .fb_lost_out(fb_lost));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict
    // Bound chosen well above the sum of all scenario waits
    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            n_fail++;
            print_verdict();
        end
    end
    task automatic chk_bit(logic got, logic exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_bit
    // Integer tolerance absorbs the design's duty rounding
    task automatic chk_pct(int got, int exp, int tol);
        n_tests++;
        if (got > exp + tol || got < exp - tol) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_pct
    task automatic chk_code(fb_code_t got, fb_code_t exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_code
    task automatic settle(int pct, output int drive_pct);
        int n;
        n = 0;
        @(posedge clk);
        #1 duty = pct;
        repeat (6 * P) @(posedge clk);
        // Sample after the edge so the design's outputs have settled
        for (int i = 0; i < P; i++) begin
            @(posedge clk);
            #1;
            if (drive === 1'b1) n++;
        end
        drive_pct = n * 100 / P;
    endtask : settle
    ////////////////////////////////////////////////////////////////////////////////
    task automatic ignition_start();
        int d;
        settle(37, d);
        chk_bit(pump_on, 1'b1);
        settle(75, d);
        chk_bit(pump_on, 1'b0);
    endtask : ignition_start
    task automatic command_bands();
        int pct[7] = '{10, 15, 37, 47, 55, 75, 90};
        logic on[7] = '{0, 1, 1, 1, 0, 0, 0};
        int fbx[7] = '{20, 60, 60, 60, 20, 60, 20};
        int d;
        for (int i = 0; i < 7; i++) begin
            settle(pct[i], d);
            chk_bit(pump_on, on[i]);
            chk_pct(d, on[i] ? 2 * pct[i] : 0, 2);
            chk_pct(fb_pct, fbx[i], 1);
            chk_code(fb_code, fbx[i] == 20 ? FB_INVALID : FB_NORMAL);
        end
    endtask : command_bands
    task automatic feedback_priority();
        int d;
        #1 fitted = 1'b0;
        settle(37, d);
        chk_pct(fb_pct, 40, 1);
        #1 fitted = 1'b1;
        crash_bad = 1'b1;
        settle(37, d);
        chk_pct(fb_pct, 40, 1);
        chk_code(fb_code, FB_EVENT);
        #1 sec_fault = 1'b1;
        settle(37, d);
        chk_pct(fb_pct, 80, 1);
        chk_code(fb_code, FB_SECONDARY);
        #1 sec_fault = 1'b0;
        crash_bad = 1'b0;
        settle(37, d);
        chk_pct(fb_pct, 60, 1);
    endtask : feedback_priority
    task automatic silent_lines();
        int d;
        #1 run = 1'b0;
        repeat (7 * P) @(posedge clk);
        #1;
        chk_bit(absent, 1'b1);
        chk_bit(pump_on, 1'b0);
        chk_pct(fb_pct, 20, 1);
        #1 rst = 1'b1;
        repeat (4 * P) @(posedge clk);
        #1;
        chk_bit(fb_lost, 1'b1);
        #1 rst = 1'b0;
        run = 1'b1;
        @(posedge clk);
        #1 chk_bit(absent, 1'b1);
        settle(47, d);
        chk_bit(absent, 1'b0);
        chk_bit(fb_lost, 1'b0);
    endtask : silent_lines
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        mrst = 1'b0;
        ignition_start();
        command_bands();
        feedback_priority();
        silent_lines();
        print_verdict();
    end
endmodule : tb_fuel_pump_duty_cycle_link
`default_nettype wire
